/* rtl/hpc_parser.sv */
`include "hpc_cfg.svh"
module hpc_parser (
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire hpc_pkg::hpc_char_t RX_DATA_IN,
  input wire logic RX_VALID_IN,
  output logic RX_READY_OUT,
  output hpc_pkg::hpc_char_t TX_DATA_OUT,
  output logic TX_VALID_OUT,
  input wire logic TX_READY_IN,
  output logic LASER_ON_OUT,
  output logic [7:0] SYMBOLOGY_ENABLE_A_OUT,
  output logic [7:0] SYMBOLOGY_ENABLE_B_OUT,
  output logic [7:0] CONVERSION_CHECK_OPTIONS_OUT,
  output logic [7:0] DECODE_MISC_OPTIONS_OUT,
  output logic [7:0] BUFFER_BEEPER_OPTIONS_OUT,
  output logic [7:0] SUPPLEMENTAL_OPTIONS_OUT,
  output logic BEEPER_EN_OUT,
  output logic CODE39_BUFFER_EN_OUT,
  output logic NO_DECODE_MSG_EN_OUT
);
  import hpc_pkg::*;

  localparam logic [7:0] RST_VAL [`HPC_PARAM_CNT] = '{`HPC_RST_P0, `HPC_RST_P1,
    `HPC_RST_P2, `HPC_RST_P3, `HPC_RST_P4, `HPC_RST_P5};
  localparam logic [7:0] BIT_MASK [`HPC_PARAM_CNT] = '{`HPC_MASK_P0, `HPC_MASK_P1,
    `HPC_MASK_P2, `HPC_MASK_P3, `HPC_MASK_P4, `HPC_MASK_P5};

  hpc_state_t state_reg;
  hpc_char_t cmd_reg, rx_lrc_reg, tx_single_reg, tx_cmd_reg, tx_lrc_reg, tx_data_reg;
  logic bad_reg, half_reg, tx_valid_reg, laser_reg;
  logic [1:0] hdr_cnt_reg;
  logic [3:0] hi_nib_reg;
  logic [4:0] byte_cnt_reg, tx_idx_reg, tx_len_reg;
  logic [7:0] pnum_reg;
  logic [7:0] param_reg [`HPC_PARAM_CNT];
  logic [7:0] shadow_reg [`HPC_PARAM_CNT];
  logic [`HPC_PARAM_CNT-1:0] mask_reg;
  logic rx_take, exec_ok, commit, tx_load, tx_done, nib_ok;
  hpc_char_t c, tx_char, hdr_exp, data_byte;
  logic [4:0] dpos;
  logic [3:0] dbyte;

  // Receive handshake and decoded character
  assign c = RX_DATA_IN;
  assign RX_READY_OUT = (state_reg != ST_SEND);
  assign rx_take = RX_VALID_IN && RX_READY_OUT;
  assign nib_ok = (c[7:4] == `HPC_NIB_HI);
  assign data_byte = {hi_nib_reg, c[3:0]};
  assign exec_ok = (state_reg == ST_LRC) && rx_take && (c == rx_lrc_reg) && !bad_reg
    && !half_reg;
  assign commit = exec_ok && ((cmd_reg == `HPC_CMD_DNL_ALL) || (cmd_reg == `HPC_CMD_DNL_SPEC));

  // Expected header character by position
  always_comb begin
    unique case (hdr_cnt_reg)
      2'd0: hdr_exp = `HPC_HDR_S;
      2'd1: hdr_exp = `HPC_HDR_T;
      default: hdr_exp = `HPC_HDR_I;
    endcase
  end

  // Frame receiver and response selection
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 8'h00;
      rx_lrc_reg <= 8'h00;
      bad_reg <= 1'b0;
      half_reg <= 1'b0;
      hdr_cnt_reg <= 2'd0;
      hi_nib_reg <= 4'h0;
      byte_cnt_reg <= 5'h00;
      tx_single_reg <= 8'h00;
      tx_cmd_reg <= 8'h00;
      tx_len_reg <= 5'h00;
    end else if (rx_take) begin
      unique case (state_reg)
        ST_IDLE: begin
          rx_lrc_reg <= 8'h00;
          bad_reg <= 1'b0;
          half_reg <= 1'b0;
          hdr_cnt_reg <= 2'd0;
          byte_cnt_reg <= 5'h00;
          if (c == `HPC_STX) begin
            state_reg <= ST_HDR;
          end else if (c == `HPC_ESC) begin
            tx_single_reg <= `HPC_ACK;
            tx_len_reg <= `HPC_LEN_SINGLE;
            state_reg <= ST_SEND;
          end
        end
        ST_HDR: begin
          rx_lrc_reg <= rx_lrc_reg ^ c;
          if (c != hdr_exp) begin
            bad_reg <= 1'b1;
          end
          hdr_cnt_reg <= hdr_cnt_reg + 2'd1;
          if (hdr_cnt_reg == 2'd2) begin
            state_reg <= ST_CMD;
          end
        end
        ST_CMD: begin
          rx_lrc_reg <= rx_lrc_reg ^ c;
          cmd_reg <= c;
          if (c < `HPC_CMD_IDENT || c > `HPC_CMD_DNL_SPEC) begin
            bad_reg <= 1'b1;
          end
          state_reg <= ST_DATA;
        end
        ST_DATA: begin
          rx_lrc_reg <= rx_lrc_reg ^ c;
          if (c == `HPC_ETX) begin
            state_reg <= ST_LRC;
          end else begin
            if (!nib_ok) begin
              bad_reg <= 1'b1;
            end
            half_reg <= !half_reg;
            hi_nib_reg <= c[3:0];
            if (half_reg) begin
              byte_cnt_reg <= byte_cnt_reg + 5'h01;
            end
          end
        end
        ST_LRC: begin
          state_reg <= ST_SEND;
          tx_cmd_reg <= cmd_reg;
          tx_single_reg <= exec_ok ? `HPC_ACK : `HPC_NAK;
          tx_len_reg <= `HPC_LEN_SINGLE;
          if (exec_ok && cmd_reg == `HPC_CMD_IDENT) begin
            tx_len_reg <= `HPC_LEN_IDENT;
          end else if (exec_ok && cmd_reg == `HPC_CMD_UPLOAD) begin
            tx_len_reg <= `HPC_LEN_UPLOAD;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end else if (state_reg == ST_SEND && tx_done) begin
      state_reg <= ST_IDLE;
    end
  end

  // Parameter number of a specific download pair
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      pnum_reg <= 8'h00;
    end else if (rx_take && state_reg == ST_DATA && nib_ok && half_reg && !byte_cnt_reg[0]) begin
      pnum_reg <= data_byte;
    end
  end

  // Staging area and committed parameter store, one entry each
  genvar gi;
  generate
    for (gi = 0; gi < `HPC_PARAM_CNT; gi++) begin : g_param
      logic hit_all, hit_spec;
      assign hit_all = (cmd_reg == `HPC_CMD_DNL_ALL)
        && (byte_cnt_reg == 5'(gi));
      assign hit_spec = (cmd_reg == `HPC_CMD_DNL_SPEC) && byte_cnt_reg[0]
        && (pnum_reg == 8'(gi));
      always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
          shadow_reg[gi] <= 8'h00;
          mask_reg[gi] <= 1'b0;
        end else if (rx_take && state_reg == ST_IDLE) begin
          mask_reg[gi] <= 1'b0;
        end else if (rx_take && state_reg == ST_DATA && c != `HPC_ETX && half_reg
                     && (hit_all || hit_spec)) begin
          shadow_reg[gi] <= data_byte;
          mask_reg[gi] <= 1'b1;
        end
      end
      always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
          param_reg[gi] <= RST_VAL[gi];
        end else if (commit && mask_reg[gi]) begin
          param_reg[gi] <= shadow_reg[gi] & BIT_MASK[gi];
        end
      end
    end
  endgenerate

  // Parameter outputs, reserved bits cleared
  assign SYMBOLOGY_ENABLE_A_OUT = param_reg[0];
  assign SYMBOLOGY_ENABLE_B_OUT = param_reg[1];
  assign CONVERSION_CHECK_OPTIONS_OUT = param_reg[2];
  assign DECODE_MISC_OPTIONS_OUT = param_reg[3];
  assign BUFFER_BEEPER_OPTIONS_OUT = param_reg[4];
  assign SUPPLEMENTAL_OPTIONS_OUT = param_reg[5];
  assign NO_DECODE_MSG_EN_OUT = param_reg[3][`HPC_BIT_NO_DECODE];
  assign CODE39_BUFFER_EN_OUT = param_reg[4][`HPC_BIT_C39_BUFFER];
  assign BEEPER_EN_OUT = param_reg[4][`HPC_BIT_BEEPER];

  // Laser state from laser on and escape
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      laser_reg <= 1'b0;
    end else if (rx_take && state_reg == ST_IDLE && c == `HPC_ESC) begin
      laser_reg <= 1'b0;
    end else if (exec_ok && cmd_reg == `HPC_CMD_LASER_ON) begin
      laser_reg <= 1'b1;
    end
  end
  assign LASER_ON_OUT = laser_reg;

  // Response character by position
  assign dpos = tx_idx_reg - 5'h02;
  assign dbyte = dpos[4:1];
  always_comb begin
    hpc_char_t b;
    b = 8'h00;
    if (tx_cmd_reg == `HPC_CMD_IDENT) begin
      b = dbyte[0] ? `HPC_VER_1 : `HPC_VER_0;
    end else if (dbyte < 4'(`HPC_PARAM_CNT)) begin
      b = param_reg[dbyte[2:0]];
    end
    if (tx_len_reg == `HPC_LEN_SINGLE) begin
      tx_char = tx_single_reg;
    end else if (tx_idx_reg == 5'h00) begin
      tx_char = `HPC_STX;
    end else if (tx_idx_reg == 5'h01) begin
      tx_char = tx_cmd_reg;
    end else if (tx_idx_reg == tx_len_reg - 5'h02) begin
      tx_char = `HPC_ETX;
    end else if (tx_idx_reg == tx_len_reg - 5'h01) begin
      tx_char = tx_lrc_reg;
    end else begin
      tx_char = {`HPC_NIB_HI, dpos[0] ? b[3:0] : b[7:4]};
    end
  end

  // Transmit sequencer
  assign tx_load = (state_reg == ST_SEND) && (!tx_valid_reg || TX_READY_IN)
    && (tx_idx_reg < tx_len_reg);
  assign tx_done = (tx_idx_reg == tx_len_reg) && (!tx_valid_reg || TX_READY_IN);
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      tx_idx_reg <= 5'h00;
      tx_lrc_reg <= 8'h00;
      tx_data_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
    end else begin
      if (state_reg != ST_SEND) begin
        tx_idx_reg <= 5'h00;
        tx_lrc_reg <= 8'h00;
      end else if (tx_load) begin
        tx_idx_reg <= tx_idx_reg + 5'h01;
        if (tx_idx_reg != 5'h00) begin
          tx_lrc_reg <= tx_lrc_reg ^ tx_char;
        end
      end
      if (tx_load) begin
        tx_data_reg <= tx_char;
        tx_valid_reg <= 1'b1;
      end else if (TX_READY_IN) begin
        tx_valid_reg <= 1'b0;
      end
    end
  end
  assign TX_DATA_OUT = tx_data_reg;
  assign TX_VALID_OUT = tx_valid_reg;

  // Checks on the protocol engine
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);

  a_laser_on_ack: assert property ((exec_ok && cmd_reg == `HPC_CMD_LASER_ON) |=>
    LASER_ON_OUT ##1 (TX_VALID_OUT && TX_DATA_OUT == `HPC_ACK))
    else $error("laser on not acknowledged");
  a_esc_off: assert property ((rx_take && state_reg == ST_IDLE && c == `HPC_ESC) |=>
    !LASER_ON_OUT ##1 (TX_DATA_OUT == `HPC_ACK))
    else $error("escape did not turn laser off");
  a_bad_lrc_nak: assert property ((rx_take && state_reg == ST_LRC && c != rx_lrc_reg) |=>
    ##1 (TX_VALID_OUT && TX_DATA_OUT == `HPC_NAK))
    else $error("bad check not answered with NAK");
  a_params_hold: assert property (!commit |=> $stable(SYMBOLOGY_ENABLE_A_OUT)
    && $stable(SUPPLEMENTAL_OPTIONS_OUT))
    else $error("parameters changed without good frame");
  a_hdr_reject: assert property ((rx_take && state_reg == ST_HDR && c != hdr_exp) |=>
    bad_reg)
    else $error("bad header not flagged");
  a_data_nibble: assert property ((tx_load && tx_len_reg != `HPC_LEN_SINGLE
    && tx_idx_reg >= 5'h02 && tx_idx_reg < tx_len_reg - 5'h02) |=> TX_DATA_OUT[7:4] == 4'h3)
    else $error("response data not nibble coded");
  a_frame_start: assert property ((tx_load && tx_len_reg != `HPC_LEN_SINGLE
    && tx_idx_reg == 5'h00) |=> TX_DATA_OUT == `HPC_STX ##1 (TX_DATA_OUT == tx_cmd_reg
    || !$past(TX_READY_IN)))
    else $error("response frame start wrong");
  a_lrc_out: assert property ((tx_load && tx_len_reg != `HPC_LEN_SINGLE
    && tx_idx_reg == tx_len_reg - 5'h01) |=> TX_DATA_OUT == $past(tx_lrc_reg))
    else $error("response check character wrong");
  a_upload_first: assert property ((tx_load && tx_cmd_reg == `HPC_CMD_UPLOAD
    && tx_len_reg == `HPC_LEN_UPLOAD && tx_idx_reg == 5'h02)
    |=> TX_DATA_OUT == {4'h3, $past(param_reg[0][7:4])})
    else $error("upload does not begin at parameter 00");
  a_busy_block: assert property ((rx_take && state_reg == ST_LRC) |=> !RX_READY_OUT)
    else $error("receiver open while answering");
  a_ack_nak_used: assert property ((rx_take && state_reg == ST_LRC
    && cmd_reg != `HPC_CMD_IDENT && cmd_reg != `HPC_CMD_UPLOAD) |=> ##1 (TX_VALID_OUT
    && (TX_DATA_OUT == `HPC_ACK || TX_DATA_OUT == `HPC_NAK)))
    else $error("framed command not answered with ACK or NAK");

  c_laser_on: cover property (exec_ok && cmd_reg == `HPC_CMD_LASER_ON);
  c_upload: cover property (tx_load && tx_len_reg == `HPC_LEN_UPLOAD && tx_idx_reg == 5'h0f);
  c_dnl_spec: cover property (commit && cmd_reg == `HPC_CMD_DNL_SPEC);
  c_nak: cover property (tx_load && tx_char == `HPC_NAK);
endmodule

/* shared/hpc_cfg.svh */
`ifndef HPC_CFG_SVH
`define HPC_CFG_SVH
// Framing characters
`define HPC_STX 8'h02
`define HPC_ETX 8'h03
`define HPC_ESC 8'h1b
`define HPC_ACK 8'h06
`define HPC_NAK 8'h15
`define HPC_HDR_S 8'h53
`define HPC_HDR_T 8'h54
`define HPC_HDR_I 8'h49
`define HPC_NIB_HI 4'h3
// Command characters
`define HPC_CMD_IDENT 8'h44
`define HPC_CMD_LASER_ON 8'h45
`define HPC_CMD_UPLOAD 8'h46
`define HPC_CMD_DNL_ALL 8'h47
`define HPC_CMD_DNL_SPEC 8'h48
// Parameter store, offsets 0x0 to 0x5
`define HPC_PARAM_CNT 6
`define HPC_PNUM_W 8
`define HPC_RST_P0 8'he3
`define HPC_RST_P1 8'h13
`define HPC_RST_P2 8'h0c
`define HPC_RST_P3 8'h00
`define HPC_RST_P4 8'h04
`define HPC_RST_P5 8'h00
// Defined bits of each parameter, reserved bits read zero
`define HPC_MASK_P0 8'he3
`define HPC_MASK_P1 8'h1b
`define HPC_MASK_P2 8'h7f
`define HPC_MASK_P3 8'h07
`define HPC_MASK_P4 8'h06
`define HPC_MASK_P5 8'h03
// Field positions used as separate outputs
`define HPC_BIT_NO_DECODE 0
`define HPC_BIT_C39_BUFFER 1
`define HPC_BIT_BEEPER 2
// Software version string, two letters, arbitrary value
`define HPC_VER_0 8'h41
`define HPC_VER_1 8'h42
// Response lengths in characters
`define HPC_LEN_SINGLE 5'h01
`define HPC_LEN_IDENT 5'h08
`define HPC_LEN_UPLOAD 5'h10
`endif

/* shared/hpc_pkg.sv */
package hpc_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_HDR  = 6'b000010,
    ST_CMD  = 6'b000100,
    ST_DATA = 6'b001000,
    ST_LRC  = 6'b010000,
    ST_SEND = 6'b100000
  } hpc_state_t;
  typedef logic [7:0] hpc_char_t;
endpackage

/* test/hpc_host_model.sv */
// Host side of the programming link: frames commands, collects answers
module hpc_host_model (
  input wire logic clk_in,
  output hpc_pkg::hpc_char_t rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  input wire hpc_pkg::hpc_char_t tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  input wire logic slow_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import hpc_pkg::*;
  hpc_char_t send_q[$];
  hpc_char_t recv_q[$];
  logic took = 1'b0;
  // Idle values at time zero
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    tx_ready_out = 1'b0;
  end
  // Sample both handshakes on the rising edge
  always @(posedge clk_in) begin
    took = rx_valid_out && rx_ready_in;
    if (tx_valid_in && tx_ready_out) recv_q.push_back(tx_data_in);
  end
  // Offer next char only after the last one was taken; scramble a released line
  always @(negedge clk_in) begin
    if (took || !rx_valid_out) begin
      if (send_q.size() > 0) begin
        rx_data_out <= send_q.pop_front();
        rx_valid_out <= 1'b1;
      end else begin
        rx_valid_out <= 1'b0;
        rx_data_out <= ~rx_data_out;
      end
    end
    tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
  end
  // Queue one framed command with nibble data and check char
  task automatic send_cmd(input hpc_char_t cmd, input hpc_char_t d[$], input bit bad);
    hpc_char_t f[$];
    hpc_char_t lrc;
    f = '{8'h53, 8'h54, 8'h49, cmd};
    foreach (d[i]) begin
      f.push_back({4'h3, d[i][7:4]});
      f.push_back({4'h3, d[i][3:0]});
    end
    f.push_back(8'h03);
    lrc = 8'h00;
    foreach (f[i]) lrc ^= f[i];
    send_q.push_back(8'h02);
    foreach (f[i]) send_q.push_back(f[i]);
    send_q.push_back(bad ? ~lrc : lrc);
  endtask
endmodule

/* test/host_param_command_parser_tb_top.sv */
`include "hpc_cfg.svh"
module host_param_command_parser_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hpc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  hpc_char_t rx_data, tx_data;
  logic rx_valid, rx_ready, tx_valid, tx_ready, laser, beep, c39, nod;
  logic [7:0] p[6];
  int err_count = 0;
  int total_checks = 0;
  hpc_char_t exp_q[$];
  hpc_char_t none[$];

  hpc_parser DUT (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .RX_DATA_IN(rx_data),
    .RX_VALID_IN(rx_valid), .RX_READY_OUT(rx_ready), .TX_DATA_OUT(tx_data),
    .TX_VALID_OUT(tx_valid), .TX_READY_IN(tx_ready), .LASER_ON_OUT(laser),
    .SYMBOLOGY_ENABLE_A_OUT(p[0]), .SYMBOLOGY_ENABLE_B_OUT(p[1]),
    .CONVERSION_CHECK_OPTIONS_OUT(p[2]), .DECODE_MISC_OPTIONS_OUT(p[3]),
    .BUFFER_BEEPER_OPTIONS_OUT(p[4]), .SUPPLEMENTAL_OPTIONS_OUT(p[5]),
    .BEEPER_EN_OUT(beep), .CODE39_BUFFER_EN_OUT(c39), .NO_DECODE_MSG_EN_OUT(nod));

  hpc_host_model host (.clk_in(clk), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
    .rx_ready_in(rx_ready), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready), .slow_in(slow));

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // Compare one value and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Compare all six parameter outputs
  task automatic chk_params(input logic [7:0] e[6]);
    for (int i = 0; i < 6; i++) chk(p[i], e[i], "param");
  endtask

  // Expected framed response: no header, nibble data, check after the start char
  function automatic void exp_frame(input hpc_char_t cmd, input hpc_char_t d[$]);
    hpc_char_t l;
    exp_q = '{8'h02, cmd};
    foreach (d[i]) begin
      exp_q.push_back({4'h3, d[i][7:4]});
      exp_q.push_back({4'h3, d[i][3:0]});
    end
    exp_q.push_back(8'h03);
    l = 8'h00;
    for (int i = 1; i < exp_q.size(); i++) l ^= exp_q[i];
    exp_q.push_back(l);
  endfunction

  // Wait for the answer, compare each char, then make sure nothing extra follows
  task automatic expect_rx();
    int n;
    n = 0;
    while (host.recv_q.size() < exp_q.size() && n < 500) begin
      @(negedge clk);
      n++;
    end
    repeat (4) @(negedge clk);
    foreach (exp_q[i]) chk(i < host.recv_q.size() ? host.recv_q[i] : 8'hxx, exp_q[i], "tx");
    chk(8'(host.recv_q.size()), 8'(exp_q.size()), "tx count");
    host.recv_q.delete();
  endtask

  // Reset state of every output except the transmit data
  task automatic t_reset();
    chk_params('{8'he3, 8'h13, 8'h0c, 8'h00, 8'h04, 8'h00});
    chk({tx_valid, laser, rx_ready}, 8'h01, "idle");
    chk({beep, c39, nod}, 8'h04, "fields");
  endtask

  // Laser on answered with ACK, lone escape turns it off
  task automatic t_laser();
    host.send_cmd(`HPC_CMD_LASER_ON, none, 1'b0);
    exp_q = '{`HPC_ACK};
    expect_rx();
    chk(laser, 8'h01, "laser on");
    host.send_q.push_back(8'h1b);
    expect_rx();
    chk(laser, 8'h00, "laser off");
  endtask

  // Identify returns alphabetic version in a headerless frame
  task automatic t_ident();
    host.send_cmd(`HPC_CMD_IDENT, none, 1'b0);
    exp_frame(`HPC_CMD_IDENT, '{`HPC_VER_0, `HPC_VER_1});
    expect_rx();
  endtask

  // Specific download touches only named parameters
  task automatic t_spec();
    host.send_cmd(`HPC_CMD_DNL_SPEC, '{8'h00, 8'h03, 8'h04, 8'h06}, 1'b0);
    exp_q = '{`HPC_ACK};
    expect_rx();
    chk_params('{8'h03, 8'h13, 8'h0c, 8'h00, 8'h06, 8'h00});
    chk({beep, c39}, 8'h03, "fields");
  endtask

  // Full download in ascending order, then upload with a stalling host
  task automatic t_all();
    hpc_char_t v[$];
    v = '{8'ha1, 8'h1b, 8'h55, 8'h07, 8'h02, 8'h03};
    host.send_cmd(`HPC_CMD_DNL_ALL, v, 1'b0);
    exp_q = '{`HPC_ACK};
    expect_rx();
    chk_params('{8'ha1, 8'h1b, 8'h55, 8'h07, 8'h02, 8'h03});
    chk({beep, c39, nod}, 8'h03, "fields");
    slow = 1'b1;
    host.send_cmd(`HPC_CMD_UPLOAD, none, 1'b0);
    exp_frame(`HPC_CMD_UPLOAD, v);
    expect_rx();
    slow = 1'b0;
  endtask

  // Bad check, bad command and bad header in a row give NAK and keep state
  task automatic t_bad();
    hpc_char_t raw[7];
    raw = '{8'h02, 8'h53, 8'h55, 8'h49, `HPC_CMD_LASER_ON, 8'h03, 8'h09};
    host.send_cmd(`HPC_CMD_DNL_ALL, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b1);
    host.send_cmd(8'h49, none, 1'b0);
    foreach (raw[i]) host.send_q.push_back(raw[i]);
    exp_q = '{`HPC_NAK, `HPC_NAK, `HPC_NAK};
    expect_rx();
    chk_params('{8'ha1, 8'h1b, 8'h55, 8'h07, 8'h02, 8'h03});
    chk(laser, 8'h00, "laser kept off");
  endtask

  // Print counts and verdict, end the run
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #100000;
    err_count++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_laser();
    t_ident();
    t_spec();
    t_all();
    t_bad();
    summarize();
  end
endmodule
